// file: rtl/synth_cfg.svh
`ifndef SYNTH_CFG_SVH
`define SYNTH_CFG_SVH

// ----------------------------------------------------------------
// bus map
// ----------------------------------------------------------------
`define ADDR_LOAD        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_ACTIVE_BASE 8'h40
`define ADDR_ACTIVE_LAST 8'h70
`define ADDR_LSB         2
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define WORD_ZERO        32'h0000_0000

// ----------------------------------------------------------------
// select code and register numbers
// ----------------------------------------------------------------
`define SEL_MSB          3
`define SEL_LSB          0
`define REG_APPLY        4'h0
`define REG_LAST         4'hc
`define REG_REF          4
`define REG_OUT          6
`define REG_LOCK         7
`define REG_CAL          9
`define REG_CONV         10
`define REG_RESYNC       12

// ----------------------------------------------------------------
// buffered bit masks (bits 31:4 of 1..3, reference path of 4, divider select of 6)
// ----------------------------------------------------------------
`define MASK_FULL        32'hffff_fff0
`define MASK_REF         32'h07ff_bc00
`define MASK_OUT_DIV     32'h00e0_0000
`define BUFFER_ENABLE_BIT 14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LD_MODE_BIT      4
`define LD_PREC_MSB      6
`define LD_PREC_LSB      5
`define REGULATOR_BIT    7
`define SECOND_TIM_MSB   8
`define SECOND_TIM_LSB   4
`define FIRST_TIM_MSB    13
`define FIRST_TIM_LSB    9
`define TIMEOUT_MSB      23
`define TIMEOUT_LSB      14
`define BAND_DIV_MSB     31
`define BAND_DIV_LSB     24
`define CONV_EN_MSB      5
`define CONV_EN_LSB      4
`define CONV_DIV_MSB     13
`define CONV_DIV_LSB     6
`define RESYNC_MSB       31
`define RESYNC_LSB       12

`endif

// file: rtl/synth_cfg_pkg.sv
package synth_cfg_pkg;
   typedef logic [12:0][31:0] word_bank_t;

   // decoded fields of the active settings
   typedef struct packed {
      logic        lock_detect_mode;
      logic [1:0]  lock_detect_precision;
      logic        regulator_mode;
      logic [9:0]  lock_timeout_field;
      logic [4:0]  first_timing_field;
      logic [4:0]  second_timing_field;
      logic [7:0]  band_select_clock_div;
      logic [7:0]  converter_clock_div;
      logic [1:0]  converter_enable_bits;
      logic [19:0] resync_clock;
   } cfg_fields_s;
endpackage : synth_cfg_pkg

// file: rtl/synth_config_register_map.sv
`include "synth_cfg.svh"

module synth_config_register_map (
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output synth_cfg_pkg::word_bank_t      active_words,
   output synth_cfg_pkg::cfg_fields_s     cfg_fields
);
   import synth_cfg_pkg::*;

   // ----------------------------------------------------------------
   // storage and bus state
   // ----------------------------------------------------------------
   word_bank_t  shadow;
   word_bank_t  active;
   logic        aw_full;
   logic        w_full;
   logic [7:0]  waddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic [3:0]  sel;
   logic        wr_go;
   logic        commit;
   logic        word_ok;
   logic        apply;
   logic        bad_code;
   logic [7:0]  load_count;
   logic [3:0]  last_sel;
   logic        buf_en;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   assign wr_go    = aw_full && w_full && !s_axi_bvalid;
   assign sel      = wdata_q[`SEL_MSB:`SEL_LSB];
   assign word_ok  = (waddr_q == `ADDR_LOAD) && (wstrb_q == 4'hf);
   assign bad_code = sel > `REG_LAST;
   assign commit   = wr_go && word_ok && !bad_code;
   assign apply    = commit && (sel == `REG_APPLY);
   assign buf_en   = active[`REG_REF][`BUFFER_ENABLE_BIT];

   // buffered bits of a register, register six following the enable bit
   function automatic logic [31:0] db_mask(input int unsigned n, input logic buf_en);
      logic [31:0] m;
      m = `WORD_ZERO;
      if (n >= 1 && n <= 3) begin
         m = `MASK_FULL;
      end else if (n == `REG_REF) begin
         m = `MASK_REF;
      end else if (n == `REG_OUT && buf_en) begin
         m = `MASK_OUT_DIV;
      end
      return m;
   endfunction : db_mask

   // ----------------------------------------------------------------
   // shadow and active words
   // ----------------------------------------------------------------
   // own write fills the shadow and the direct bits; a zero write moves buffered bits
   always_ff @(posedge clk) begin
      if (srst) begin
         shadow <= '0;
         active <= '0;
      end else if (commit) begin
         for (int unsigned n = 0; n <= `REG_LAST; n++) begin
            if (n == 32'(sel)) begin
               shadow[n] <= wdata_q;
               active[n] <= (active[n] & db_mask(n, buf_en))
                          | (wdata_q & ~db_mask(n, buf_en));
            end else if (apply) begin
               active[n] <= (active[n] & ~db_mask(n, buf_en))
                          | (shadow[n] & db_mask(n, buf_en));
            end
         end
      end
   end

   // load counter and last code for status
   always_ff @(posedge clk) begin
      if (srst) begin
         load_count <= 8'h00;
         last_sel   <= 4'h0;
      end else if (commit) begin
         load_count <= load_count + 8'h01;
         last_sel   <= sel;
      end
   end

   // ----------------------------------------------------------------
   // axi write channels
   // ----------------------------------------------------------------
   // address side: hold one address until the response is taken
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_full       <= 1'b0;
         s_axi_awready <= 1'b0;
         waddr_q       <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full       <= 1'b1;
         s_axi_awready <= 1'b0;
         waddr_q       <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_full       <= 1'b0;
         s_axi_awready <= 1'b1;
      end else if (!aw_full && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // data side: same scheme as the address side
   always_ff @(posedge clk) begin
      if (srst) begin
         w_full       <= 1'b0;
         s_axi_wready <= 1'b0;
         wdata_q      <= `WORD_ZERO;
         wstrb_q      <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full       <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_full       <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (!w_full && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (word_ok && !bad_code) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // axi read channel
   // ----------------------------------------------------------------
   // status word and active word readback, anything else is an error
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `WORD_ZERO;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `RESP_OKAY;
         s_axi_rdata   <= `WORD_ZERO;
         if (s_axi_araddr == `ADDR_STATUS) begin
            s_axi_rdata <= {20'h0_0000, last_sel, load_count};
         end else if (s_axi_araddr >= `ADDR_ACTIVE_BASE &&
                      s_axi_araddr <= `ADDR_ACTIVE_LAST &&
                      s_axi_araddr[1:0] == 2'h0) begin
            s_axi_rdata <= active[4'(
               (s_axi_araddr - `ADDR_ACTIVE_BASE) >> `ADDR_LSB)];
         end else begin
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign active_words = active;

   // fields sliced from the active words
   assign cfg_fields.lock_detect_mode      = active[`REG_LOCK][`LD_MODE_BIT];
   assign cfg_fields.lock_detect_precision = active[`REG_LOCK][`LD_PREC_MSB:`LD_PREC_LSB];
   assign cfg_fields.regulator_mode        = active[`REG_LOCK][`REGULATOR_BIT];
   assign cfg_fields.lock_timeout_field    = active[`REG_CAL][`TIMEOUT_MSB:`TIMEOUT_LSB];
   assign cfg_fields.first_timing_field    = active[`REG_CAL][`FIRST_TIM_MSB:`FIRST_TIM_LSB];
   assign cfg_fields.second_timing_field   = active[`REG_CAL][`SECOND_TIM_MSB:`SECOND_TIM_LSB];
   assign cfg_fields.band_select_clock_div = active[`REG_CAL][`BAND_DIV_MSB:`BAND_DIV_LSB];
   assign cfg_fields.converter_clock_div   = active[`REG_CONV][`CONV_DIV_MSB:`CONV_DIV_LSB];
   assign cfg_fields.converter_enable_bits = active[`REG_CONV][`CONV_EN_MSB:`CONV_EN_LSB];
   assign cfg_fields.resync_clock          = active[`REG_RESYNC][`RESYNC_MSB:`RESYNC_LSB];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   buffered_hold_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h1 |=> active[1][31:4] == $past(active[1][31:4])
         && shadow[1] == $past(wdata_q))
      else $error("buffered word changed on its own write");

   buffered_apply_a: assert property (@(posedge clk) disable iff (srst)
      apply |=> active[2][31:4] == $past(shadow[2][31:4]))
      else $error("buffered word not applied by zero write");

   cond_buffer_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h6 && active[4][14] |=> active[6][23:21] == $past(active[6][23:21]))
      else $error("divider select not held while buffering enabled");

   cond_direct_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h6 && !active[4][14] |=> active[6] == $past(wdata_q))
      else $error("divider select not direct while buffering disabled");

   route_code_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h8 |=> active[8] == $past(wdata_q) ##1 active[8] == $past(wdata_q, 2))
      else $error("word not routed by its select code");

   cal_fields_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h9 |=> cfg_fields.lock_timeout_field == $past(wdata_q[23:14])
         && cfg_fields.band_select_clock_div == $past(wdata_q[31:24]))
      else $error("calibration fields wrong");

   conv_fields_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'ha |=> cfg_fields.converter_clock_div == $past(wdata_q[13:6]))
      else $error("converter divider wrong");

   resync_field_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'hc |=> cfg_fields.resync_clock == $past(wdata_q[31:12]))
      else $error("resync clock field wrong");

   lock_fields_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h7 |=> cfg_fields.regulator_mode == $past(wdata_q[7]))
      else $error("lock detect setup wrong");

   lock_mode_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h7 |=> cfg_fields.lock_detect_mode == $past(wdata_q[4])
         && cfg_fields.lock_detect_precision == $past(wdata_q[6:5]))
      else $error("lock detect mode or precision wrong");

   cal_timing_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h9 |=> cfg_fields.first_timing_field == $past(wdata_q[13:9])
         && cfg_fields.second_timing_field == $past(wdata_q[8:4]))
      else $error("calibration timing fields wrong");

   conv_enable_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'ha |=> cfg_fields.converter_enable_bits == $past(wdata_q[5:4]))
      else $error("converter enable bits wrong");

   route_eleven_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'hb |=> active[11] == $past(wdata_q))
      else $error("fixed word eleven not routed");

   shadow_fill_a: assert property (@(posedge clk) disable iff (srst)
      commit |=> shadow[$past(sel)] == $past(wdata_q))
      else $error("shadow word not filled by its own write");

   zero_write_a: assert property (@(posedge clk) disable iff (srst)
      apply |=> active[0] == $past(wdata_q))
      else $error("register zero word not stored");

   direct_keep_a: assert property (@(posedge clk) disable iff (srst)
      apply |=> active[7] == $past(active[7]) && active[9] == $past(active[9]))
      else $error("zero write changed an unbuffered register");

   ref_hold_a: assert property (@(posedge clk) disable iff (srst)
      commit && sel == 4'h4 |=> (active[4] & `MASK_REF) == ($past(active[4]) & `MASK_REF))
      else $error("reference path bits changed on their own write");

   ref_apply_a: assert property (@(posedge clk) disable iff (srst)
      apply |=> (active[4] & `MASK_REF) == ($past(shadow[4]) & `MASK_REF))
      else $error("reference path bits not applied by zero write");

   out_div_apply_a: assert property (@(posedge clk) disable iff (srst)
      apply && active[4][14] |=> active[6][23:21] == $past(shadow[6][23:21]))
      else $error("divider select not applied by zero write");

   refused_word_a: assert property (@(posedge clk) disable iff (srst)
      wr_go && !(word_ok && !bad_code) |=> s_axi_bresp == `RESP_SLVERR
         && active == $past(active) && shadow == $past(shadow))
      else $error("refused word changed the settings");

   status_count_a: assert property (@(posedge clk) disable iff (srst)
      commit |=> load_count == $past(load_count) + 8'h01 && last_sel == $past(sel))
      else $error("load count or last select wrong");

   // ----------------------------------------------------------------
   // bus handshake checks
   // ----------------------------------------------------------------
   aw_take_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready && aw_full)
      else $error("write address not held after take");

   w_take_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_wvalid && s_axi_wready |=> !s_axi_wready && w_full && wdata_q == $past(s_axi_wdata))
      else $error("write data not held after take");

   resp_after_a: assert property (@(posedge clk) disable iff (srst)
      wr_go |=> s_axi_bvalid)
      else $error("write response missing");

   resp_release_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && !aw_full && !w_full)
      else $error("write response not released");

   ready_return_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
      else $error("write readies not restored");

   read_answer_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");

   read_release_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not released");

   status_read_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADDR_STATUS |=>
         s_axi_rdata == {20'h0_0000, $past(last_sel), $past(load_count)}
         && s_axi_rresp == `RESP_OKAY)
      else $error("status word wrong");

endmodule : synth_config_register_map

// file: verification/host_model.sv
// ------------------------------------------------
// host controller that loads configuration words
// ------------------------------------------------
module host_model (
   input  wire logic        clk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end

   // one word per write with the caller's strobes, reserved bits as the caller gives them
   task automatic write_word(input logic [7:0] addr, input logic [31:0] data,
                             input logic [3:0] strb, output logic [1:0] resp);
      @(posedge clk);
      s_axi_awaddr  <= addr;
      s_axi_wdata   <= data;
      s_axi_wstrb   <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~addr;      // released lines do not keep their value
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~data;
         end
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : write_word

   // single read, address released once taken
   task automatic read_word(input logic [7:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
      @(posedge clk);
      s_axi_araddr  <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~addr;
         end
         if (s_axi_rvalid) begin
            data = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : read_word
endmodule : host_model

// file: verification/testbench.sv
`include "synth_cfg.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import synth_cfg_pkg::*;

   localparam logic [31:0] PATTERN_EIGHT = 32'h0000_0008;  // plain default for the fixed word
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   word_bank_t active_words;
   cfg_fields_s cfg_fields;
   int num_errors = 0;
   int n_tests = 0;

   // 50 ns clock
   always #25 clk = ~clk;

   host_model host (.clk(clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   synth_config_register_map DUT (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .active_words(active_words), .cfg_fields(cfg_fields));

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      n_tests++;
      if (seen !== expected) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask : check

   // load one word and compare the response code
   task automatic load(input logic [31:0] word, input logic [3:0] strb, input logic [1:0] exp);
      logic [1:0] resp;
      host.write_word(`ADDR_LOAD, word, strb, resp);
      check({30'h0, resp}, {30'h0, exp});
   endtask : load

   task automatic summarize;
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   // direct registers land in their decoded fields
   task automatic test_fields;
      load(32'h0000_00d7, 4'hf, `RESP_OKAY);
      load({8'ha5, 10'h2c3, 5'h11, 5'h0e, 4'h9}, 4'hf, `RESP_OKAY);
      load({18'h0, 8'h5a, 2'b11, 4'ha}, 4'hf, `RESP_OKAY);
      load({20'habcde, 8'h00, 4'hc}, 4'hf, `RESP_OKAY);
      check(active_words[7], 32'h0000_00d7);
      check({28'h0, cfg_fields.lock_detect_mode, cfg_fields.lock_detect_precision,
             cfg_fields.regulator_mode}, 32'h0000_000d);
      check({cfg_fields.band_select_clock_div, cfg_fields.lock_timeout_field,
             cfg_fields.first_timing_field, cfg_fields.second_timing_field, 4'h0},
            {8'ha5, 10'h2c3, 5'h11, 5'h0e, 4'h0});
      check({18'h0, cfg_fields.converter_clock_div, cfg_fields.converter_enable_bits, 4'h0},
            {18'h0, 8'h5a, 2'b11, 4'h0});
      check({cfg_fields.resync_clock, 12'h0}, {20'habcde, 12'h0});
   endtask : test_fields

   // shadow words wait for a register-zero load; divider select waits only when enabled
   task automatic test_buffer;
      load(32'h0123_4561, 4'hf, `RESP_OKAY);
      load(32'h1234_5672, 4'hf, `RESP_OKAY);
      check(active_words[1], 32'h0000_0001);
      check(active_words[2], 32'h0000_0002);
      load(32'h0600_4004, 4'hf, `RESP_OKAY);
      check(active_words[4], 32'h0000_4004);
      load(32'h0000_1230, 4'hf, `RESP_OKAY);
      check(active_words[0], 32'h0000_1230);
      check(active_words[1], 32'h0123_4561);
      check(active_words[2], 32'h1234_5672);
      check(active_words[4], 32'h0600_4004);
      load(32'h00a0_0806, 4'hf, `RESP_OKAY);
      check(active_words[6], 32'h0000_0806);
      load(32'h0000_2340, 4'hf, `RESP_OKAY);
      check(active_words[6], 32'h00a0_0806);
      load(32'h0600_0004, 4'hf, `RESP_OKAY);
      check(active_words[4], 32'h0600_0004);
      load(32'h0060_0006, 4'hf, `RESP_OKAY);
      check(active_words[6], 32'h0060_0006);
   endtask : test_buffer

   // fixed patterns, refused writes and bus reads
   task automatic test_refuse;
      logic [1:0]  resp;
      logic [31:0] data;
      load(PATTERN_EIGHT, 4'hf, `RESP_OKAY);
      load({28'h0, 4'hb}, 4'hf, `RESP_OKAY);
      check(active_words[8], PATTERN_EIGHT);
      check(active_words[11], 32'h0000_000b);
      host.write_word(`ADDR_STATUS, 32'h0000_0009, 4'hf, resp);
      check({30'h0, resp}, {30'h0, `RESP_SLVERR});
      load(32'hffff_fff9, 4'h7, `RESP_SLVERR);
      load(32'h1111_111d, 4'hf, `RESP_SLVERR);
      check(active_words[9], {8'ha5, 10'h2c3, 5'h11, 5'h0e, 4'h9});
      host.read_word(`ADDR_STATUS, data, resp);
      check(data, 32'h0000_0b0e);
      check({30'h0, resp}, {30'h0, `RESP_OKAY});
      host.read_word(8'h64, data, resp);
      check(data, {8'ha5, 10'h2c3, 5'h11, 5'h0e, 4'h9});
      check({30'h0, resp}, {30'h0, `RESP_OKAY});
      host.read_word(8'h08, data, resp);
      check(data, `WORD_ZERO);
      check({30'h0, resp}, {30'h0, `RESP_SLVERR});
   endtask : test_refuse

   // ------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      check({31'h0, |active_words}, 32'h0000_0000);
      test_fields();
      test_buffer();
      test_refuse();
      summarize();
   end

   // cut a hang short
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize();
   end
endmodule : testbench
